// >>> common/uhbm_cfg.svh
// address map, field positions and fixed figures of the host buffer memory
`ifndef UHBM_CFG_SVH
`define UHBM_CFG_SVH

// cpu byte address window of the buffer
`define UHBM_CPU_MEM_BASE    16'h0400
`define UHBM_CPU_DESC_END    16'h0FFF
`define UHBM_CPU_PAYLOAD_LO  16'h1000
`define UHBM_CPU_MEM_END     16'hFFFF
// byte offset to 64-bit word address shift
`define UHBM_WORD_SHIFT      3
// internal word address ranges per area
`define UHBM_ISO_WBASE       13'h0000
`define UHBM_INT_WBASE       13'h0080
`define UHBM_ASYNC_WBASE     13'h0100
`define UHBM_PAYLOAD_WBASE   13'h0180
// descriptor field of an internal word address
`define UHBM_AREA_MSB        8
`define UHBM_AREA_LSB        7
`define UHBM_IDX_MSB         6
`define UHBM_IDX_LSB         2
// descriptor shape
`define UHBM_DESC_PER_AREA   32
`define UHBM_DW_PER_DESC     8
// prefetch pointer step, one double word
`define UHBM_PF_STEP         16'h0004
// double word lane enables
`define UHBM_DW_LO           2'h1
`define UHBM_DW_HI           2'h2
`define UHBM_DW_NONE         2'h0
// peak path figure and word width
`define UHBM_PEAK_MBPS       240
`define UHBM_WORD_BYTES      8

`endif

// >>> common/uhbm_pkg.sv
// shared types of the host buffer memory block
package uhbm_pkg;

	// area field of a word address
	typedef enum logic [1:0] {
		UHBM_AREA_ISO,
		UHBM_AREA_INT,
		UHBM_AREA_ASYNC,
		UHBM_AREA_PAYLOAD
	} uhbm_area_t;

	// owner of an outstanding memory read
	typedef enum logic {
		UHBM_OWN_CPU,
		UHBM_OWN_ENG
	} uhbm_owner_t;

	// one request to the shared 64-bit memory
	typedef struct packed {
		logic        req;
		logic        we;
		logic [12:0] waddr;
		logic [1:0]  dw_en;
		logic [63:0] wdata;
	} uhbm_mem_req_t;

	// one bit per descriptor for each of the three areas
	typedef struct packed {
		logic [31:0] iso;
		logic [31:0] intr;
		logic [31:0] async;
	} uhbm_vec3_t;

	// whole state of the top module
	typedef struct packed {
		logic        wr_pend;
		logic [15:0] wr_addr;
		logic [31:0] wr_data;
		logic [15:0] pf_ptr;
		logic        pf_armed;
		logic        pf_busy;
		logic        pf_stale;
		logic        pf_valid;
		logic [31:0] pf_data;
		logic        rd_pend;
		uhbm_owner_t rd_owner;
		uhbm_vec3_t  done;
		logic        err;
		logic        irq;
		uhbm_area_t  zone;
	} uhbm_state_t;

endpackage

// >>> dv/tb_top.sv
// self-checking bench of the host buffer memory block
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("unexpected %s exp %h got %h", nm, ex, got); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_clk, i_arst_n, i_cpu_wr, i_cpu_pf_load, i_cpu_rd, i_eng_req, i_eng_we, i_eng_done;
	logic        o_cpu_rd_valid, o_cpu_err, o_eng_gnt, o_eng_rvalid, o_irq, e, ok;
	logic [15:0] i_cpu_addr, a;
	logic [31:0] i_cpu_wdata, o_cpu_rdata, d;
	logic [12:0] i_eng_waddr, i_eng_done_waddr, w;
	logic [1:0]  i_eng_dw_en;
	logic [63:0] i_eng_wdata, o_eng_rdata, rd, wd;
	logic [31:0] mem [logic [15:0]];
	logic [15:0] adr [16] = '{0: 16'h0400, 1: 16'h07FC, 2: 16'h0800, 3: 16'h0BFC, 4: 16'h0C00,
		5: 16'h0FFC, 6: 16'h1000, 7: 16'hFFFC, default: 16'h0};
	int          seed = 32'h0C07;
	int          n_mismatch = 0;
	int          checks_done = 0;
	uhbm_pkg::uhbm_area_t o_cpu_zone;
	uhbm_pkg::uhbm_vec3_t i_done_clr, i_irq_or_mask, i_irq_and_mask, o_done;
	uhbm_top i_uhbm_top (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cpu_wr(i_cpu_wr), .i_cpu_addr(i_cpu_addr),
		.i_cpu_wdata(i_cpu_wdata), .i_cpu_pf_load(i_cpu_pf_load), .i_cpu_rd(i_cpu_rd),
		.o_cpu_rd_valid(o_cpu_rd_valid), .o_cpu_rdata(o_cpu_rdata), .o_cpu_err(o_cpu_err),
		.o_cpu_zone(o_cpu_zone), .i_eng_req(i_eng_req), .i_eng_we(i_eng_we), .i_eng_waddr(i_eng_waddr),
		.i_eng_dw_en(i_eng_dw_en), .i_eng_wdata(i_eng_wdata), .o_eng_gnt(o_eng_gnt),
		.o_eng_rvalid(o_eng_rvalid), .o_eng_rdata(o_eng_rdata), .i_eng_done(i_eng_done),
		.i_eng_done_waddr(i_eng_done_waddr), .i_done_clr(i_done_clr), .i_irq_or_mask(i_irq_or_mask),
		.i_irq_and_mask(i_irq_and_mask), .o_done(o_done), .o_irq(o_irq)
	);
	uhbm_eng_model u_eng (
		.i_clk(i_clk), .i_gnt(o_eng_gnt), .i_rvalid(o_eng_rvalid), .i_rdata(o_eng_rdata),
		.o_req(i_eng_req), .o_we(i_eng_we), .o_waddr(i_eng_waddr), .o_dw_en(i_eng_dw_en),
		.o_wdata(i_eng_wdata)
	);
	// expected word address, zone and flag vector
	function automatic logic [12:0] wof(input logic [15:0] x);
		wof = 13'((x - 16'h0400) >> 3);
	endfunction
	function automatic logic [1:0] zof(input logic [15:0] x);
		zof = (x < 16'h1000) ? x[11:10] - 2'h1 : 2'h3;
	endfunction
	function automatic logic [95:0] dvec(input logic [12:0] x);
		dvec = 96'h0;
		dvec[{2'h2 - x[8:7], x[6:2]}] = 1'b1;
	endfunction
	task automatic finish_test();
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// posted write, spaced two cycles
	task automatic cpu_wr(input logic [15:0] x, input logic [31:0] v, output logic er);
		@(posedge i_clk);
		i_cpu_wr <= 1'b1;
		i_cpu_addr <= x;
		i_cpu_wdata <= v;
		@(posedge i_clk);
		i_cpu_wr <= 1'b0;
		@(negedge i_clk);
		er = o_cpu_err;
		if (!er)
			mem[x] = v;
	endtask
	task automatic pf_load(input logic [15:0] x, output logic er);
		@(posedge i_clk);
		i_cpu_pf_load <= 1'b1;
		i_cpu_addr <= x;
		@(posedge i_clk);
		i_cpu_pf_load <= 1'b0;
		@(negedge i_clk);
		er = o_cpu_err;
	endtask
	// bounded wait for a prefetched word, then take it
	task automatic pop(output logic [31:0] v);
		for (int n = 0; n < 40; n++)
		begin
			@(negedge i_clk);
			if (o_cpu_rd_valid === 1'b1)
				break;
		end
		if (o_cpu_rd_valid !== 1'b1)
		begin
			n_mismatch++;
			finish_test();
		end
		v = o_cpu_rdata;
		@(posedge i_clk);
		i_cpu_rd <= 1'b1;
		@(posedge i_clk);
		i_cpu_rd <= 1'b0;
	endtask
	task automatic eng_rd(input logic [15:0] x);
		logic [63:0] r;
		logic        k;
		u_eng.xfer(1'b0, wof(x), 2'h0, 64'h0, r, k);
		`CHK("eng_gnt", 1'b1, k)
		`CHK("eng_rd", mem[x], x[2] ? r[63:32] : r[31:0])
	endtask
	task automatic done_pulse(input logic [12:0] x, input logic clr);
		@(posedge i_clk);
		i_eng_done <= !clr;
		i_eng_done_waddr <= x;
		i_done_clr <= clr ? '1 : '0;
		@(posedge i_clk);
		i_eng_done <= 1'b0;
		i_done_clr <= '0;
		@(negedge i_clk);
	endtask
	initial
	begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	initial
	begin
		{i_arst_n, i_cpu_wr, i_cpu_pf_load, i_cpu_rd, i_eng_done} = '0;
		{i_cpu_addr, i_cpu_wdata, i_eng_done_waddr} = '0;
		{i_done_clr, i_irq_or_mask, i_irq_and_mask} = '0;
		repeat (16) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		i_cpu_rd <= 1'b1;
		@(posedge i_clk);
		i_cpu_rd <= 1'b0;
		@(negedge i_clk);
		`CHK("pop_err", 1'b1, o_cpu_err)
		foreach (adr[i])
			if (i < 3)
			begin
				cpu_wr(i == 0 ? 16'h03FC : 16'h0401 + 16'(i), 32'h0, e);
				`CHK("bad_wr", 1'b1, e)
			end
		pf_load(16'h03F8, e);
		`CHK("bad_load", 1'b1, e)
		foreach (adr[i])
		begin
			if (i > 7)
				adr[i] = 16'h0400 + (16'($random(seed)) & 16'hFBFC);
			cpu_wr(adr[i], $random(seed), e);
			`CHK("wr_err", 1'b0, e)
		end
		foreach (adr[i])
		begin
			pf_load(adr[i], e);
			`CHK("zone", zof(adr[i]), o_cpu_zone)
			pop(d);
			// descriptor and payload words come back as software wrote them
			`CHK("cpu_rd", mem[adr[i]], d)
			eng_rd(adr[i]);
		end
		for (int i = 0; i < 4; i++)
		begin
			w = 13'h0180 + 13'($random(seed) & 32'h0FFF);
			wd = {$random(seed), $random(seed)};
			// upper double word of one payload word, high lane only
			u_eng.xfer(1'b1, w, 2'h2, wd, rd, ok);
			`CHK("eng_wr_gnt", 1'b1, ok)
			a = 16'h0400 + {w, 3'h4};
			mem[a] = wd[63:32];
			pf_load(a, e);
			pop(d);
			`CHK("eng_wr", mem[a], d)
			// engine starts one cycle late so it meets the pending write
			fork
				cpu_wr(16'h3000 + 16'(i * 4), $random(seed), e);
				begin
					@(posedge i_clk);
					eng_rd(adr[i]);
				end
			join
		end
		pf_load(16'h3000, e);
		for (int i = 0; i < 4; i++)
		begin
			pop(d);
			`CHK("pf_seq", mem[16'h3000 + 16'(i * 4)], d)
		end
		i_irq_or_mask <= '1;
		for (int i = 0; i < 3; i++)
		begin
			w = {4'h0, 2'(i), 5'($random(seed)), 2'h0};
			done_pulse(w, 1'b0);
			`CHK("done", dvec(w), 96'(o_done))
			`CHK("irq_or", 1'b1, o_irq)
			done_pulse(w, 1'b1);
			`CHK("irq_off", 1'b0, o_irq)
		end
		done_pulse(13'h0180, 1'b0);
		`CHK("payload_done", 96'h0, 96'(o_done))
		i_irq_or_mask <= '0;
		i_irq_and_mask <= dvec(13'h0000) | dvec(13'h017C);
		done_pulse(13'h0000, 1'b0);
		`CHK("irq_and1", 1'b0, o_irq)
		done_pulse(13'h017C, 1'b0);
		`CHK("irq_and2", 1'b1, o_irq)
		finish_test();
	end
endmodule // tb_top

// >>> dv/uhbm_chk_properties.sv
// port assertions of the host buffer memory block
module uhbm_chk (
	// clock, reset
	input wire logic                 i_clk,
	input wire logic                 i_arst_n,
	// cpu side
	input wire logic                 i_cpu_wr,
	input wire logic [15:0]          i_cpu_addr,
	input wire logic                 i_cpu_pf_load,
	input wire logic                 i_cpu_rd,
	input wire logic                 o_cpu_rd_valid,
	input wire logic                 o_cpu_err,
	input wire uhbm_pkg::uhbm_area_t o_cpu_zone,
	// engine side
	input wire logic                 i_eng_req,
	input wire logic                 i_eng_we,
	input wire logic                 o_eng_gnt,
	input wire logic                 o_eng_rvalid,
	input wire logic                 i_eng_done,
	input wire logic [12:0]          i_eng_done_waddr,
	// flags
	input wire uhbm_pkg::uhbm_vec3_t i_done_clr,
	input wire uhbm_pkg::uhbm_vec3_t i_irq_or_mask,
	input wire uhbm_pkg::uhbm_vec3_t o_done,
	input wire logic                 o_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        ok_a; // aligned and inside the buffer
	logic [1:0]  zexp; // zone of the cpu address
	logic [6:0]  dbit; // flag position of a completion
	logic [95:0] dv;
	logic [95:0] om;
	assign ok_a = i_cpu_addr >= 16'h0400 && i_cpu_addr[1:0] == 2'h0;
	assign zexp = (i_cpu_addr < 16'h1000) ? i_cpu_addr[11:10] - 2'h1 : 2'h3;
	assign dbit = {2'h2 - i_eng_done_waddr[8:7], i_eng_done_waddr[6:2]};
	assign dv = o_done;
	assign om = i_irq_or_mask;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);
	a_err_low: assert property (i_cpu_wr && i_cpu_addr < 16'h0400 |=> o_cpu_err)
		else $error("write below buffer not refused");
	a_err_align: assert property (i_cpu_wr && i_cpu_addr[1:0] != 2'h0 |=> o_cpu_err)
		else $error("misaligned write not refused");
	a_zone_map: assert property (i_cpu_pf_load && ok_a && !i_cpu_wr |=> o_cpu_zone == $past(zexp))
		else $error("zone does not match address");
	a_gnt_cause: assert property (o_eng_gnt |-> i_eng_req)
		else $error("grant without request");
	a_eng_read: assert property (i_eng_req && o_eng_gnt && !i_eng_we |=> o_eng_rvalid)
		else $error("engine read word missing");
	a_done_set: assert property (i_eng_done && i_eng_done_waddr < 13'h0180 |=> dv[$past(dbit)])
		else $error("completion flag not set");
	a_irq_or: assert property ((|(dv & om)) && i_done_clr == '0 |=> o_irq)
		else $error("masked flag left irq low");
	a_pf_wait: assert property (i_cpu_pf_load && ok_a && !i_cpu_wr && !i_eng_req && !$past(i_cpu_wr)
		&& !$past(i_cpu_wr, 2) ##1 (!i_eng_req && !i_cpu_wr && !i_cpu_pf_load && !i_cpu_rd)[*2]
		|=> o_cpu_rd_valid)
		else $error("prefetch late");
	a_fair_turn: assert property (i_eng_req && !o_eng_gnt |=> !i_eng_req || o_eng_gnt)
		else $error("engine lost twice");
	a_pop_empty: assert property (i_cpu_rd && !o_cpu_rd_valid && !i_cpu_pf_load |=> o_cpu_err)
		else $error("empty pop not refused");
endmodule // uhbm_chk

bind uhbm_top uhbm_chk u_chk (
	.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cpu_wr(i_cpu_wr), .i_cpu_addr(i_cpu_addr),
	.i_cpu_pf_load(i_cpu_pf_load), .i_cpu_rd(i_cpu_rd), .o_cpu_rd_valid(o_cpu_rd_valid),
	.o_cpu_err(o_cpu_err), .o_cpu_zone(o_cpu_zone), .i_eng_req(i_eng_req), .i_eng_we(i_eng_we),
	.o_eng_gnt(o_eng_gnt), .o_eng_rvalid(o_eng_rvalid), .i_eng_done(i_eng_done),
	.i_eng_done_waddr(i_eng_done_waddr), .i_done_clr(i_done_clr), .i_irq_or_mask(i_irq_or_mask),
	.o_done(o_done), .o_irq(o_irq)
);

// >>> dv/uhbm_eng_model.sv
// host engine model on the buffer memory port
module uhbm_eng_model (
	input  wire logic        i_clk,
	input  wire logic        i_gnt,
	input  wire logic        i_rvalid,
	input  wire logic [63:0] i_rdata,
	output logic             o_req,
	output logic             o_we,
	output logic [12:0]      o_waddr,
	output logic [1:0]       o_dw_en,
	output logic [63:0]      o_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		o_req = 1'b0;
		o_we = 1'b0;
		o_waddr = 13'h0000;
		o_dw_en = 2'h0;
		o_wdata = 64'h0;
	end
	// one transfer, held until the grant is seen or 50 cycles pass
	// word addresses are always aligned
	task automatic xfer(input logic we, input logic [12:0] wa, input logic [1:0] en,
		input logic [63:0] wd, output logic [63:0] rd, output logic ok);
		@(posedge i_clk);
		o_req <= 1'b1;
		o_we <= we;
		o_waddr <= wa;
		o_dw_en <= en;
		o_wdata <= wd;
		ok = 1'b0;
		for (int n = 0; n < 50 && !ok; n++)
		begin
			@(negedge i_clk);
			ok = i_gnt;
		end
		@(posedge i_clk);
		// released address and data lines show the inverse, not the last value
		o_req <= 1'b0;
		o_waddr <= ~wa;
		o_wdata <= ~wd;
		@(negedge i_clk);
		ok = ok && (we || i_rvalid);
		rd = i_rdata;
	endtask
endmodule // uhbm_eng_model

// >>> rtl/uhbm_arb.sv
// two-way alternating arbiter in front of the buffer memory
module uhbm_arb (
	// clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_arst_n,
	// requesters
	input  wire uhbm_pkg::uhbm_mem_req_t i_cpu,
	input  wire uhbm_pkg::uhbm_mem_req_t i_eng,
	// grants and chosen request
	output logic                        o_gnt_cpu,
	output logic                        o_gnt_eng,
	output uhbm_pkg::uhbm_mem_req_t     o_sel
);

	// state: which side won the last contested cycle
	typedef struct packed {
		logic last_eng;
	} uhbm_arb_state_t;

	uhbm_arb_state_t s_q;
	uhbm_arb_state_t s_d;

	// grant decision; a lone requester always wins
	always_comb
	begin
		s_d = s_q;
		o_gnt_cpu = 1'b0;
		o_gnt_eng = 1'b0;
		if (i_cpu.req && i_eng.req)
		begin
			o_gnt_eng = !s_q.last_eng;
			o_gnt_cpu = s_q.last_eng;
			s_d.last_eng = !s_q.last_eng;
		end
		else
		begin
			o_gnt_cpu = i_cpu.req;
			o_gnt_eng = i_eng.req;
		end
		o_sel = o_gnt_eng ? i_eng : i_cpu;
		o_sel.req = o_gnt_cpu || o_gnt_eng;
	end

	// state register; cpu is favoured first after reset
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s_q <= '{last_eng: 1'b1};
		else
			s_q <= s_d;
	end

endmodule // uhbm_arb

// >>> rtl/uhbm_ram.sv
// single port 64-bit buffer memory with double word write lanes
module uhbm_ram #(
	parameter int AW = 13,
	parameter int DW = 64
) (
	// clock
	input  wire logic                    i_clk,
	// arbitrated request
	input  wire uhbm_pkg::uhbm_mem_req_t i_req,
	// read word, one cycle after the request
	output logic [DW-1:0]                o_rdata
);

	// storage; not reset, software fills it
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge i_clk)
	begin
		if (i_req.req && i_req.we)
		begin
			if (i_req.dw_en[0])
				mem[i_req.waddr[AW-1:0]][DW/2-1:0] <= i_req.wdata[DW/2-1:0];
			if (i_req.dw_en[1])
				mem[i_req.waddr[AW-1:0]][DW-1:DW/2] <= i_req.wdata[DW-1:DW/2];
		end
		else if (i_req.req)
			o_rdata <= mem[i_req.waddr[AW-1:0]];
	end

endmodule // uhbm_ram

// >>> rtl/uhbm_top.sv
// host buffer memory: cpu window, prefetch reads, arbitration and completion interrupt
`include "uhbm_cfg.svh"

module uhbm_top #(
	parameter int AW = 13
) (
	// clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_arst_n,
	// cpu posted write
	input  wire logic                  i_cpu_wr,
	input  wire logic [15:0]           i_cpu_addr,
	input  wire logic [31:0]           i_cpu_wdata,
	// cpu prefetched read
	input  wire logic                  i_cpu_pf_load,
	input  wire logic                  i_cpu_rd,
	output logic                       o_cpu_rd_valid,
	output logic [31:0]                o_cpu_rdata,
	output logic                       o_cpu_err,
	output uhbm_pkg::uhbm_area_t       o_cpu_zone,
	// host engine memory port
	input  wire logic                  i_eng_req,
	input  wire logic                  i_eng_we,
	input  wire logic [12:0]           i_eng_waddr,
	input  wire logic [1:0]            i_eng_dw_en,
	input  wire logic [63:0]           i_eng_wdata,
	output logic                       o_eng_gnt,
	output logic                       o_eng_rvalid,
	output logic [63:0]                o_eng_rdata,
	// descriptor completion from the engine
	input  wire logic                  i_eng_done,
	input  wire logic [12:0]           i_eng_done_waddr,
	// completion flags and interrupt
	input  wire uhbm_pkg::uhbm_vec3_t  i_done_clr,
	input  wire uhbm_pkg::uhbm_vec3_t  i_irq_or_mask,
	input  wire uhbm_pkg::uhbm_vec3_t  i_irq_and_mask,
	output uhbm_pkg::uhbm_vec3_t       o_done,
	output logic                       o_irq
);

	// registered state and its next value
	uhbm_pkg::uhbm_state_t   s_q;
	uhbm_pkg::uhbm_state_t   s_d;

	// requests toward the arbiter
	uhbm_pkg::uhbm_mem_req_t cpu_mreq;
	uhbm_pkg::uhbm_mem_req_t eng_mreq;
	uhbm_pkg::uhbm_mem_req_t mem_req;
	logic                    gnt_cpu;
	logic                    gnt_eng;
	logic [63:0]             ram_rdata;

	// cpu side decode helpers
	logic [15:0]             wr_off;
	logic [15:0]             pf_off;
	logic                    cpu_wr_sel;
	logic                    cpu_pf_sel;

	// offsets from the buffer base
	// subtract base before shift
	assign wr_off = s_q.wr_addr - `UHBM_CPU_MEM_BASE;
	assign pf_off = s_q.pf_ptr - `UHBM_CPU_MEM_BASE;

	// a pending write goes first so a later read sees it
	assign cpu_wr_sel = s_q.wr_pend;
	// fetch ahead while the cpu has nothing waiting
	// prefetch instead of wait states
	assign cpu_pf_sel = !s_q.wr_pend && s_q.pf_armed && !s_q.pf_valid && !s_q.pf_busy;

	// cpu request; a 32-bit write lands in one half of the word
	always_comb
	begin
		cpu_mreq.req = cpu_wr_sel || cpu_pf_sel;
		cpu_mreq.we = cpu_wr_sel;
		cpu_mreq.waddr = cpu_wr_sel ? wr_off[15:`UHBM_WORD_SHIFT] : pf_off[15:`UHBM_WORD_SHIFT];
		if (!cpu_wr_sel)
			cpu_mreq.dw_en = `UHBM_DW_NONE;
		else if (wr_off[2])
			cpu_mreq.dw_en = `UHBM_DW_HI;
		else
			cpu_mreq.dw_en = `UHBM_DW_LO;
		cpu_mreq.wdata = {s_q.wr_data, s_q.wr_data};
	end

	// engine request passes straight through
	// engine serves the internal hub ports
	always_comb
	begin
		eng_mreq.req = i_eng_req;
		eng_mreq.we = i_eng_we;
		eng_mreq.waddr = i_eng_waddr;
		eng_mreq.dw_en = i_eng_dw_en;
		eng_mreq.wdata = i_eng_wdata;
	end

	// alternating arbiter between cpu and engine
	uhbm_arb u_arb (
		.i_clk     (i_clk),
		.i_arst_n  (i_arst_n),
		.i_cpu     (cpu_mreq),
		.i_eng     (eng_mreq),
		.o_gnt_cpu (gnt_cpu),
		.o_gnt_eng (gnt_eng),
		.o_sel     (mem_req)
	);

	// the shared 64-bit buffer
	uhbm_ram #(
		.AW (AW),
		.DW (64)
	) u_ram (
		.i_clk   (i_clk),
		.i_req   (mem_req),
		.o_rdata (ram_rdata)
	);

	// next state of every register
	always_comb
	begin
		logic        cpu_ok;
		logic [15:0] cpu_off;
		logic [15:0] next_ptr;
		logic [1:0]  done_area;
		logic [4:0]  done_idx;
		uhbm_pkg::uhbm_vec3_t set_v;
		uhbm_pkg::uhbm_vec3_t hit_or;
		uhbm_pkg::uhbm_vec3_t hit_and;
		cpu_ok = 1'b0;
		cpu_off = 16'h0000;
		next_ptr = 16'h0000;
		done_area = 2'h0;
		done_idx = 5'h00;
		set_v = '0;
		hit_or = '0;
		hit_and = '0;
		s_d = s_q;
		s_d.err = 1'b0;

		// nothing below the base is buffer
		// low two address bits must be zero
		cpu_ok = (i_cpu_addr >= `UHBM_CPU_MEM_BASE) && (i_cpu_addr[1:0] == 2'h0);
		cpu_off = i_cpu_addr - `UHBM_CPU_MEM_BASE;

		// zone of the latest cpu write or prefetch load
		if (i_cpu_wr || i_cpu_pf_load)
		begin
			if (i_cpu_addr >= `UHBM_CPU_PAYLOAD_LO)
				s_d.zone = uhbm_pkg::UHBM_AREA_PAYLOAD;
			else
				s_d.zone = uhbm_pkg::uhbm_area_t'(cpu_off[11:10]);
		end

		// a granted write frees the holding slot
		if (gnt_cpu && cpu_wr_sel)
			s_d.wr_pend = 1'b0;

		// capture a new cpu write; never stalls the cpu bus
		if (i_cpu_wr)
		begin
			if (!cpu_ok)
				s_d.err = 1'b1;
			// slot still full: the access is lost and flagged
			else if (s_q.wr_pend && !(gnt_cpu && cpu_wr_sel))
				s_d.err = 1'b1;
			else
			begin
				s_d.wr_pend = 1'b1;
				s_d.wr_addr = i_cpu_addr;
				s_d.wr_data = i_cpu_wdata;
				// keep a valid prefetched copy coherent; a fetch still in flight returns the old word
				if (s_q.pf_valid && (i_cpu_addr[15:2] == s_q.pf_ptr[15:2]))
					s_d.pf_data = i_cpu_wdata;
			end
		end

		// remember who owns the read word due next cycle
		s_d.rd_pend = (gnt_cpu && cpu_pf_sel) || (gnt_eng && !i_eng_we);
		s_d.rd_owner = gnt_eng ? uhbm_pkg::UHBM_OWN_ENG : uhbm_pkg::UHBM_OWN_CPU;
		if (gnt_cpu && cpu_pf_sel)
			s_d.pf_busy = 1'b1;

		// prefetch return; a reload in flight discards it
		if (s_q.rd_pend && (s_q.rd_owner == uhbm_pkg::UHBM_OWN_CPU))
		begin
			s_d.pf_busy = 1'b0;
			s_d.pf_stale = 1'b0;
			if (!s_q.pf_stale)
			begin
				s_d.pf_valid = 1'b1;
				s_d.pf_data = pf_off[2] ? ram_rdata[63:32] : ram_rdata[31:0];
			end
		end

		// cpu takes the prefetched word and the pointer moves on
		if (i_cpu_rd)
		begin
			if (!s_q.pf_valid)
				s_d.err = 1'b1;
			else
			begin
				next_ptr = s_q.pf_ptr + `UHBM_PF_STEP;
				s_d.pf_valid = 1'b0;
				s_d.pf_ptr = next_ptr;
				// stop at the top of the window
				if (next_ptr < `UHBM_CPU_MEM_BASE)
					s_d.pf_armed = 1'b0;
			end
		end

		// new start address; wins over a pop in the same cycle
		if (i_cpu_pf_load)
		begin
			if (!cpu_ok)
				s_d.err = 1'b1;
			else
			begin
				s_d.pf_ptr = i_cpu_addr;
				s_d.pf_armed = 1'b1;
				s_d.pf_valid = 1'b0;
				s_d.pf_stale = s_d.pf_busy;
			end
		end

		// completion address to area and slot
		// four words hold eight double words
		done_area = i_eng_done_waddr[`UHBM_AREA_MSB:`UHBM_AREA_LSB];
		done_idx = i_eng_done_waddr[`UHBM_IDX_MSB:`UHBM_IDX_LSB];
		if (i_eng_done && (i_eng_done_waddr < `UHBM_PAYLOAD_WBASE))
		begin
			case (uhbm_pkg::uhbm_area_t'(done_area))
				uhbm_pkg::UHBM_AREA_ISO:   set_v.iso[done_idx] = 1'b1;
				uhbm_pkg::UHBM_AREA_INT:   set_v.intr[done_idx] = 1'b1;
				uhbm_pkg::UHBM_AREA_ASYNC: set_v.async[done_idx] = 1'b1;
				default:                   set_v = '0;
			endcase
		end
		// a completion in the clearing cycle is kept
		s_d.done = (s_q.done & ~i_done_clr) | set_v;

		hit_or = s_d.done & i_irq_or_mask;
		hit_and = s_d.done | ~i_irq_and_mask;
		s_d.irq = (|hit_or) || ((|i_irq_and_mask) && (&hit_and));
	end

	// state register
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// cpu outputs come from the state flops
	assign o_cpu_rd_valid = s_q.pf_valid;
	assign o_cpu_rdata = s_q.pf_data;
	assign o_cpu_err = s_q.err;
	assign o_cpu_zone = s_q.zone;

	// engine outputs; read data is the ram output flop
	assign o_eng_gnt = gnt_eng;
	assign o_eng_rvalid = s_q.rd_pend && (s_q.rd_owner == uhbm_pkg::UHBM_OWN_ENG);
	assign o_eng_rdata = ram_rdata;

	// completion flags and interrupt line
	assign o_done = s_q.done;
	assign o_irq = s_q.irq;

endmodule // uhbm_top
